// ==== inc/bcrc_pkg.sv ====
// Purpose: constants, register map and byte update function of the byte crc engine
// Assumes: 100 MHz mclk, 32-bit Avalon-MM slave, registers in the low byte of each word
// Notes:   shared by the top module and the input buffer
package bcrc_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam int        BCRC_ADDR_W     = 5;
    localparam int        BCRC_DATA_W     = 32;
    localparam int        BCRC_BE_W       = 4;
    localparam logic [4:0] BCRC_OFS_INPUT  = 5'h00;
    localparam logic [4:0] BCRC_OFS_CKLOW  = 5'h04;
    localparam logic [4:0] BCRC_OFS_CKHIGH = 5'h08;
    localparam logic [4:0] BCRC_OFS_CTRL   = 5'h0c;

    // ************************************************************
    // fields, widths and reset values
    // ************************************************************
    localparam int         BCRC_BYTE_W        = 8;
    localparam int         BCRC_SUM_W         = 16;
    localparam int         BCRC_POLYNOMIAL_SELECT_SEL_BIT  = 0;
    localparam int         BCRC_FIFO_DEPTH    = 2;
    localparam logic [7:0]  BCRC_INPUT_RST    = 8'h00;
    localparam logic [15:0] BCRC_SUM_RST      = 16'h0000;
    localparam logic        BCRC_POLYNOMIAL_SELECT_RST     = 1'b0;
    localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CCITT   = 16'h1021;
    localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CRC16   = 16'h8005;

    // ************************************************************
    // one byte folded into the running checksum, msb first
    // ************************************************************
    function automatic logic [15:0] bcrc_fold_byte(input logic [15:0] sum,
                                                   input logic [7:0]  data,
                                                   input logic        polynomial_select_sel);
        logic [15:0] tmp;
        logic [15:0] gen;
        logic        top;
        gen = polynomial_select_sel ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT;
        tmp = sum ^ {data, 8'h00};
        for (int i = 0; i < BCRC_BYTE_W; i++)
        begin
            top = tmp[15];
            tmp = {tmp[14:0], 1'b0};
            if (top)
            begin
                tmp = tmp ^ gen;
            end
        end
        return tmp;
    endfunction

endpackage

// ==== inc/bcrc_strm_if.sv ====
// Purpose: valid/ready byte stream between the bus side and the crc engine
// Assumes: one clock, transfer when valid and ready are both high at an edge
// Notes:   src drives data and valid, snk drives ready
`timescale 1ns/100ps
interface bcrc_strm_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // bcrc_strm_if

// ==== rtl/bcrc_fifo2.sv ====
// Purpose: small buffer between the input register write and the crc engine
// Assumes: DEPTH of at least one; one clock, synchronous reset
// Notes:   full and empty are exact, so a stalled engine stalls the bus write
`timescale 1ns/100ps
module bcrc_fifo2
    import bcrc_pkg::*;
#(
    parameter int W     = BCRC_BYTE_W,
    parameter int DEPTH = BCRC_FIFO_DEPTH
)(
    input  wire logic   mclk,
    input  wire logic   reset,
    bcrc_strm_if.snk    fill,
    bcrc_strm_if.src    drain
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;

    wire push = fill.valid && fill.ready;
    wire pop  = drain.valid && drain.ready;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign fill.ready  = (count_q != CW'(DEPTH));
    assign drain.valid = (count_q != '0);
    assign drain.data  = mem_q[rd_ptr_q];

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= fill.data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= push ? next_ptr(wr_ptr_q) : wr_ptr_q;
            rd_ptr_q <= pop ? next_ptr(rd_ptr_q) : rd_ptr_q;
            count_q  <= CW'(count_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop});
        end
    end

endmodule // bcrc_fifo2

// ==== rtl/bcrc_top.sv ====
// Purpose: byte-wide 16-bit crc engine behind an Avalon-MM slave
// Assumes: 100 MHz mclk, synchronous active-high reset, master holds its request
// Notes:   checksum and control accesses wait until all queued bytes are folded
//
// How it works
// - low checksum byte: read/write, resets zero
// - high checksum byte: read/write, resets zero
// - control bit 0 picks polynomial, resets 0
// - control bits 7..1 read zero, ignore writes
// - only the two fixed polynomials exist
// - each input write with lane 0 enabled folds one byte in
// - result ready before next access completes
// - byte xored into checksum high byte
// - shift left, xor generator on carry out
// - eight steps per byte, result chains on
// - final checksum readable as two bytes
// - input byte register read/write, resets zero
`timescale 1ns/100ps
module bcrc_top
    import bcrc_pkg::*;
#(
    parameter int DEPTH = BCRC_FIFO_DEPTH
)(
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic [BCRC_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [BCRC_DATA_W-1:0] writedata,
    input  wire logic [BCRC_BE_W-1:0]   byteenable,
    output logic      [BCRC_DATA_W-1:0] readdata,
    output logic                        waitrequest
);

    // ************************************************************
    // state
    // ************************************************************
    logic                   wait_q;
    logic [BCRC_DATA_W-1:0] readdata_q;
    logic [BCRC_BYTE_W-1:0] input_q;
    logic [BCRC_SUM_W-1:0]  sum_q;
    logic                   polynomial_select_q;
    logic [BCRC_BYTE_W-1:0] stage_q;
    logic                   stage_v_q;

    bcrc_strm_if #(.W(BCRC_BYTE_W)) in_if ();
    bcrc_strm_if #(.W(BCRC_BYTE_W)) out_if ();

    bcrc_fifo2 #(
        .W     (BCRC_BYTE_W),
        .DEPTH (DEPTH)
    ) u_buf (
        .mclk  (mclk),
        .reset (reset),
        .fill  (in_if.snk),
        .drain (out_if.src)
    );

    // ************************************************************
    // address decode and handshake
    // ************************************************************
    wire hit_in    = (address == BCRC_OFS_INPUT);
    wire hit_low   = (address == BCRC_OFS_CKLOW);
    wire hit_high  = (address == BCRC_OFS_CKHIGH);
    wire hit_ctrl  = (address == BCRC_OFS_CTRL);
    wire hit_sum   = hit_low || hit_high || hit_ctrl;
    wire req       = read || write;
    wire eng_idle  = !out_if.valid && !stage_v_q;

    // queued bytes must land first so readback and polynomial change stay in order
    wire can_take  = hit_in  ? (!write || in_if.ready) :
                     hit_sum ? eng_idle : 1'b1;
    wire accept    = req && wait_q && can_take;
    wire commit    = req && !wait_q;
    wire wr_lane0  = write && commit && byteenable[0];
    wire wr_in     = wr_lane0 && hit_in;
    wire wr_low    = wr_lane0 && hit_low;
    wire wr_high   = wr_lane0 && hit_high;
    wire wr_ctrl   = wr_lane0 && hit_ctrl;

    // ************************************************************
    // read mux, unmapped reads return zero
    // ************************************************************
    wire [BCRC_BYTE_W-1:0] rd_byte = hit_in   ? input_q :
                                     hit_low  ? sum_q[7:0] :
                                     hit_high ? sum_q[15:8] :
                                     hit_ctrl ? {7'h00, polynomial_select_q} : 8'h00;

    // ************************************************************
    // byte path: bus write, buffer, one stage, checksum fold
    // ************************************************************
    assign in_if.valid  = wr_in;
    assign in_if.data   = writedata[7:0];
    assign out_if.ready = !stage_v_q;

    wire take_byte = out_if.valid && out_if.ready;

    // a fold and a software write never coincide: sum writes wait for idle
    wire [BCRC_SUM_W-1:0] sum_d =
        stage_v_q ? bcrc_fold_byte(sum_q, stage_q, polynomial_select_q) :
        wr_low    ? {sum_q[15:8], writedata[7:0]} :
        wr_high   ? {writedata[7:0], sum_q[7:0]} : sum_q;

    wire polynomial_select_d = wr_ctrl ? writedata[BCRC_POLYNOMIAL_SELECT_SEL_BIT] : polynomial_select_q;
    wire [BCRC_BYTE_W-1:0] input_d = wr_in ? writedata[7:0] : input_q;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= !wait_q || !accept;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            readdata_q <= '0;
        end
        else if (accept && read)
        begin
            readdata_q <= {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sum_q   <= BCRC_SUM_RST;
            polynomial_select_q  <= BCRC_POLYNOMIAL_SELECT_RST;
            input_q <= BCRC_INPUT_RST;
        end
        else
        begin
            sum_q   <= sum_d;
            polynomial_select_q  <= polynomial_select_d;
            input_q <= input_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            stage_v_q <= 1'b0;
            stage_q   <= '0;
        end
        else
        begin
            stage_v_q <= take_byte;
            stage_q   <= take_byte ? out_if.data : stage_q;
        end
    end

    assign readdata    = readdata_q;
    assign waitrequest = wait_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence byte_in_idle_s;
        wr_in && eng_idle;
    endsequence

    sequence fold_done_s;
        ##1 take_byte ##1 stage_v_q ##1 !stage_v_q;
    endsequence

    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest held low for more than one cycle");

    byte_folds_a: assert property (byte_in_idle_s |-> fold_done_s)
        else $error("input byte not folded in time");

    fold_value_a: assert property (stage_v_q |=>
        sum_q == bcrc_fold_byte($past(sum_q), $past(stage_q), $past(polynomial_select_q)))
        else $error("checksum fold result wrong");

    first_step_a: assert property (stage_v_q && sum_q == 16'h0000 && stage_q == 8'h01 |=>
        sum_q == (polynomial_select_q ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT))
        else $error("single bit step does not give the generator");

    ctrl_upper_a: assert property (accept && read && hit_ctrl |=>
        readdata[31:1] == 31'h0 && readdata[0] == polynomial_select_q)
        else $error("control readback wrong");

    polynomial_select_write_a: assert property (wr_ctrl |=> polynomial_select_q == $past(writedata[0]))
        else $error("polynomial select not written");

    low_write_a: assert property (wr_low |=>
        sum_q[7:0] == $past(writedata[7:0]) && sum_q[15:8] == $past(sum_q[15:8]))
        else $error("checksum low byte write wrong");

    high_write_a: assert property (wr_high |=>
        sum_q[15:8] == $past(writedata[7:0]) && sum_q[7:0] == $past(sum_q[7:0]))
        else $error("checksum high byte write wrong");

    sum_read_a: assert property (accept && read && hit_high |-> eng_idle ##1
        readdata[7:0] == sum_q[15:8])
        else $error("checksum read before fold finished");

    no_overflow_a: assert property (in_if.valid |-> in_if.ready)
        else $error("input byte pushed into full buffer");

    // ************************************************************
    // checks: byte accounting and register holds
    // ************************************************************
    // bytes owed catch a lost or doubled fold that a lucky sum would hide
    localparam int OW = $clog2(DEPTH + 2);

    logic [OW-1:0] owed_q;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            owed_q <= '0;
        end
        else
        begin
            owed_q <= OW'(owed_q + OW'(wr_in) - OW'(stage_v_q));
        end
    end

    sequence busy_sum_req_s;
        req && wait_q && hit_sum && !eng_idle;
    endsequence

    sequence lane_off_s;
        write && commit && !byteenable[0];
    endsequence

    // first edge after release: nothing left over from before reset
    reset_state_a: assert property ($fell(reset) |->
        waitrequest && readdata == '0 && sum_q == BCRC_SUM_RST &&
        polynomial_select_q == BCRC_POLYNOMIAL_SELECT_RST && input_q == BCRC_INPUT_RST)
        else $error("state after reset not cleared");

    input_write_a: assert property (wr_in |=> input_q == $past(writedata[7:0]))
        else $error("input byte register not written");

    input_read_a: assert property (accept && read && hit_in |=>
        readdata == {24'h000000, $past(input_q)})
        else $error("input byte register readback wrong");

    // input reads never wait, unlike checksum and control accesses
    input_answer_a: assert property (read && wait_q && hit_in |=> !waitrequest)
        else $error("input byte read not answered at once");

    // a checksum read must never see a half-folded queue
    sum_stall_a: assert property (busy_sum_req_s |=> waitrequest)
        else $error("checksum access answered while bytes were queued");

    low_read_a: assert property (accept && read && hit_low |-> eng_idle ##1
        readdata[7:0] == sum_q[7:0])
        else $error("checksum low byte read before fold finished");

    // lane 0 off: the access completes but nothing may change
    lane_off_a: assert property (lane_off_s |=>
        polynomial_select_q == $past(polynomial_select_q) && input_q == $past(input_q) &&
        ($past(hit_in) || sum_q == $past(sum_q)))
        else $error("write with lane 0 disabled changed a register");

    sum_held_a: assert property (!stage_v_q && !wr_low && !wr_high |=>
        sum_q == $past(sum_q))
        else $error("checksum changed without a fold or a write");

    // a polynomial change mid-stream would corrupt the running sum
    polynomial_select_held_a: assert property (!wr_ctrl |=> polynomial_select_q == $past(polynomial_select_q))
        else $error("polynomial select changed without a write");

    // the stage takes a new byte only after its fold, so folds never chain
    stage_once_a: assert property (stage_v_q |=> !stage_v_q)
        else $error("one byte folded twice");

    owed_limit_a: assert property (owed_q <= OW'(DEPTH + 1))
        else $error("more bytes owed than buffer and stage hold");

    // idle means buffer and stage empty, so every pushed byte is in the sum
    idle_owes_a: assert property (eng_idle |-> owed_q == '0)
        else $error("engine idle with a byte still unfolded");

endmodule // bcrc_top

// ==== verification/bcrc_top_tb.sv ====
// Purpose: self-checking bench for the byte crc engine over its Avalon-MM slave
// Assumes: 100 MHz mclk, synchronous active-high reset held 8 cycles
// Notes:   expected checksums are constants worked out by hand, never from the design
`timescale 1ns/100ps
module bcrc_top_tb;
    import bcrc_pkg::*;

    // ************************************************************
    // clock, reset, bus signals
    // ************************************************************
    logic                   mclk = 1'b0;
    logic                   reset = 1'b1;
    logic [BCRC_ADDR_W-1:0] address = '0;
    logic                   read = 1'b0;
    logic                   write = 1'b0;
    logic [BCRC_DATA_W-1:0] writedata = '0;
    logic [BCRC_BE_W-1:0]   byteenable = '0;
    logic [BCRC_DATA_W-1:0] readdata;
    logic                   waitrequest;
    int                     failures = 0;
    int                     checks = 0;
    int                     cyc = 0;
    logic [31:0]            rd;

    localparam logic [15:0] CC1 [0:7] = '{16'h0000, 16'h1021, 16'h2042, 16'h3063,
                                          16'h4084, 16'h50a5, 16'h60c6, 16'h70e7};
    localparam logic [15:0] C161 [0:7] = '{16'h0000, 16'h8005, 16'h800f, 16'h000a,
                                           16'h801b, 16'h001e, 16'h0014, 16'h8011};
    localparam logic [7:0]  SB [0:3] = '{8'h78, 8'h56, 8'h34, 8'h12};
    localparam logic [15:0] CCS [0:3] = '{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa};
    localparam logic [15:0] C16S [0:3] = '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43};

    always #5 mclk = ~mclk;

    bcrc_top DUT (
        .mclk        (mclk),
        .reset       (reset),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest)
    );

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // an edge passes after release, so a following request never lands in the same step
    task automatic bus_write(input logic [4:0] a, input logic [7:0] d, input logic be0);
        address    <= a;
        writedata  <= {24'h000000, d};
        byteenable <= {3'b000, be0};
        write      <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        address <= a;
        read    <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic expect_reg(input logic [4:0] a, input logic [7:0] exp);
        bus_read(a, rd);
        check(rd, {24'h000000, exp});
    endtask

    task automatic expect_sum(input logic [15:0] exp);
        expect_reg(BCRC_OFS_CKHIGH, exp[15:8]);
        expect_reg(BCRC_OFS_CKLOW, exp[7:0]);
    endtask

    task automatic clear_sum();
        bus_write(BCRC_OFS_CKLOW, 8'h00, 1'b1);
        bus_write(BCRC_OFS_CKHIGH, 8'h00, 1'b1);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        expect_reg(BCRC_OFS_INPUT, 8'h00);
        expect_reg(BCRC_OFS_CKLOW, 8'h00);
        expect_reg(BCRC_OFS_CKHIGH, 8'h00);
        expect_reg(BCRC_OFS_CTRL, 8'h00);
        $display("test reset values done");

        bus_write(BCRC_OFS_CKLOW, 8'ha5, 1'b1);
        bus_write(BCRC_OFS_CKHIGH, 8'h5a, 1'b1);
        bus_write(BCRC_OFS_CKLOW, 8'hff, 1'b0);
        bus_write(5'h14, 8'h77, 1'b1);
        expect_reg(BCRC_OFS_CKLOW, 8'ha5);
        expect_reg(BCRC_OFS_CKHIGH, 8'h5a);
        expect_reg(5'h14, 8'h00);
        bus_write(BCRC_OFS_CTRL, 8'hfe, 1'b1);
        expect_reg(BCRC_OFS_CTRL, 8'h00);
        bus_write(BCRC_OFS_CTRL, 8'hff, 1'b1);
        expect_reg(BCRC_OFS_CTRL, 8'h01);
        $display("test register access done");

        // single bytes 0 to 7 from zero, both polynomials
        for (int p = 0; p < 2; p++)
        begin
            bus_write(BCRC_OFS_CTRL, p[7:0], 1'b1);
            expect_reg(BCRC_OFS_CTRL, p[7:0]);
            for (int d = 0; d < 8; d++)
            begin
                clear_sum();
                bus_write(BCRC_OFS_INPUT, d[7:0], 1'b1);
                expect_reg(BCRC_OFS_INPUT, d[7:0]);
                expect_sum(p ? C161[d] : CC1[d]);
            end
        end
        $display("test single byte done");

        // word 5678 then 1234, each low byte first; read after each, then back to back
        for (int p = 0; p < 2; p++)
        begin
            bus_write(BCRC_OFS_CTRL, p[7:0], 1'b1);
            clear_sum();
            for (int i = 0; i < 4; i++)
            begin
                bus_write(BCRC_OFS_INPUT, SB[i], 1'b1);
                expect_sum(p ? C16S[i] : CCS[i]);
            end
            clear_sum();
            for (int i = 0; i < 4; i++)
                bus_write(BCRC_OFS_INPUT, SB[i], 1'b1);
            expect_sum(p ? C16S[3] : CCS[3]);
        end
        $display("test byte sequence done");

        // ignored input write must not fold a byte
        clear_sum();
        bus_write(BCRC_OFS_INPUT, 8'h01, 1'b0);
        expect_sum(16'h0000);
        $display("test disabled write done");
        conclude();
    end
endmodule // bcrc_top_tb
